// [design/clc_rx_link_regs.svh]
// register indices, field positions and reset values of the cell receive link block
`ifndef CLC_RX_LINK_REGS_SVH
`define CLC_RX_LINK_REGS_SVH

// register indices; byte address is four times the index
`define CLC_IDX_CTRL       18'h30824
`define CLC_IDX_TXID       18'h30825
`define CLC_IDX_CFG        18'h30826
`define CLC_IDX_STAT_A     18'h3082a
`define CLC_IDX_STAT_B     18'h3082b
`define CLC_IDX_RXID       18'h3082c
`define CLC_IDX_SYNC       18'h3082e

// control byte fields, data bit = 7 - documented bit
`define CLC_CTRL_LOCK      7
`define CLC_CTRL_LOOP      6
`define CLC_CTRL_TXOFF     5
`define CLC_CTRL_RXOFF     4
`define CLC_CTRL_PINH      3
`define CLC_CTRL_SINH      2
`define CLC_CTRL_AUTO      1
`define CLC_CTRL_REALIGN   0

// link cell configuration byte
`define CLC_CFG_AUTORM     7
`define CLC_CFG_REJOIN     6
`define CLC_CFG_MODE_HI    5
`define CLC_CFG_MODE_LO    4

// status bytes
`define CLC_SA_ALIGN       2
`define CLC_SA_URUN        1
`define CLC_SA_ORUN        0
`define CLC_SB_OOF         6
`define CLC_SB_EXSEQ       5
`define CLC_SB_SEQ         4
`define CLC_SB_PAR         3
`define CLC_SB_SECT        2
`define CLC_SB_OVF         1
`define CLC_SB_RDI         0
`define CLC_SY_SEEN        1
`define CLC_SY_GOOD        0

// reset values
`define CLC_CTRL_RST       8'h00
`define CLC_TXID_RST       8'h00
`define CLC_CFG_RST        8'h00
`define CLC_RXID_RST       8'h00

`endif

// [design/clc_pkg.sv]
// types shared by the cell receive link block
package clc_pkg;
	typedef logic [7:0] clc_byte_t;
	typedef enum logic [1:0] {
		ALIGN_IDLE = 2'b00,
		ALIGN_WAIT = 2'b01,
		ALIGN_RUN  = 2'b10
	} clc_align_t;
endpackage : clc_pkg

// [design/clc_rx_link.sv]
// cell mode receive link: extraction, checks, drop decision, link control and apb registers
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "clc_rx_link_regs.svh"
// Summary of operation
// - strip cell words, compare carried parity with computed parity, flag mismatch.
// - predict next header sequence number; mismatch sets status and pulses fabric error.
// - cells go to the fabric whole, one at a time.
// - filling starts only at the first frame-alignment pair after framing acquired.
// - optional automatic removal of a link with excessive sequence errors.
// - control bit 0 picks receiver lock source: reference or data.
// - control bit 1 loops transmit into receive and turns off output buffers.
// - control bit 2 sends idle cells once any cell in progress ends.
// - control bit 3 stops all receive cell reads from the link.
// - bit 4 clear drops parity-errored cells with a drop pulse; set passes them.
// - bit 5 clear drops sequence-errored cells with a drop pulse; set passes them.
// - control bit 6 enables own overhead generation.
// - rising write of bit 7 centres the alignment read pointer in mode 00.
// - transmit link number goes into F1 when overhead generation is on.
// - read-only register keeps the link number received in F1.
// - quiet status: cell alignment bit 5, underrun bit 6, overrun bit 7.
// - quiet status byte of frame, sequence, parity, overflow and defect faults.
// - status bit 6 shows the frame-alignment pair has been seen.
// - link-good rises only on a frame boundary, falls any time.
// - bit 0 of each register byte is its most significant bit.
// - received words arrive framed and descrambled, 32 bits per clock.
// - receive data leaves on pclk; the crossing to the port controller clock lies beyond this block.
module clc_rx_link #(
	parameter int        CELL_WORDS = 4,
	parameter logic[7:0] EXCESS_SEQ = 8'h04
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [19:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [31:0]       rx_word,
	input  wire logic              rx_word_valid,
	input  wire logic              rx_frame_start,
	input  wire logic              rx_frame_acquired,
	input  wire logic              rx_oof,
	input  wire logic              rx_f1_valid,
	input  wire clc_pkg::clc_byte_t rx_f1_byte,
	input  wire logic              rx_section_parity_err,
	input  wire logic              rx_remote_defect,
	input  wire logic              rx_fifo_ovf_evt,
	input  wire logic              cell_align_err_evt,
	input  wire logic              tx_underrun_evt,
	input  wire logic              tx_overrun_evt,
	input  wire logic              tx_cell_busy,
	output logic      [31:0]       cell_word,
	output logic                   cell_valid,
	output logic                   cell_sop,
	output logic                   cell_eop,
	output logic                   seq_error_ind,
	output logic                   cell_discard_pulse,
	output logic                   rx_lock_source_sel,
	output logic                   internal_loopback_en,
	output logic                   hs_out_buf_en,
	output logic                   tx_send_idle,
	output logic                   auto_overhead_gen,
	output clc_pkg::clc_byte_t     tx_f1_byte,
	output logic                   fifo_center_pulse,
	output logic                   receive_link_healthy,
	output logic                   align_bytes_seen
);
	import clc_pkg::*;

	localparam int IW = (CELL_WORDS > 1) ? $clog2(CELL_WORDS) : 1;
	localparam logic [IW-1:0] LAST = IW'(CELL_WORDS - 1);

	typedef struct packed {
		clc_align_t                 align;
		logic [7:0]                 ctrl;
		logic [7:0]                 txid;
		logic [7:0]                 cfg;
		logic [7:0]                 rxid;
		logic [2:0]                 stat_a;
		logic [6:0]                 stat_b;
		logic                       removed;
		logic                       seen;
		logic                       healthy;
		logic                       good_arm;
		logic                       seq_lock;
		logic                       cell_serr;
		logic [7:0]                 exp_seq;
		logic [7:0]                 par_acc;
		logic [7:0]                 serr_run;
		logic [IW-1:0]              wcnt;
		logic [IW-1:0]              ocnt;
		logic                       out_act;
		logic [CELL_WORDS-1:0][31:0] mem;
		logic [31:0]                ow;
		logic                       ov;
		logic                       osop;
		logic                       oeop;
		logic                       seq_ind;
		logic                       drop_p;
		logic                       center_p;
		logic                       tx_idle;
		logic                       buf_en;
		logic [7:0]                 f1_out;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
	} clc_state_t;

	clc_state_t s_reg;
	clc_state_t s_next;

	// parity of one word folded into a byte; used for every payload word
	function automatic logic [7:0] clc_byte_xor(input logic [31:0] w);
		clc_byte_xor = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
	endfunction : clc_byte_xor

	function automatic logic clc_hit(input logic [19:0] a, input logic [17:0] idx);
		clc_hit = (a[19:2] == idx) && (a[1:0] == 2'b00);
	endfunction : clc_hit

	always_comb begin
		logic       wr;
		logic       rd;
		logic       lost;
		logic       take;
		logic       serr;
		logic       perr;
		logic       drop;
		logic [7:0] acc;
		logic [7:0] rbyte;
		logic [2:0] set_a;
		logic [2:0] clr_a;
		logic [6:0] set_b;
		logic [6:0] clr_b;
		logic       excess;
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		lost = rx_oof || !rx_frame_acquired;
		take = 1'b0;
		serr = 1'b0;
		perr = 1'b0;
		drop = 1'b0;
		acc = 8'h00;
		rbyte = 8'h00;
		set_a = 3'h0;
		clr_a = 3'h0;
		set_b = 7'h00;
		clr_b = 7'h00;
		excess = 1'b0;
		s_next = s_reg;
		s_next.seq_ind = 1'b0;
		s_next.drop_p = 1'b0;
		s_next.center_p = 1'b0;
		s_next.ov = 1'b0;
		s_next.osop = 1'b0;
		s_next.oeop = 1'b0;
		s_next.pready = 1'b1;

		// register writes take effect at the access edge
		if (wr && clc_hit(paddr, `CLC_IDX_CTRL)) begin
			// only a written 0-to-1 edge counts, and only without multi-link alignment
			if (pwdata[`CLC_CTRL_REALIGN] && !s_reg.ctrl[`CLC_CTRL_REALIGN] &&
			    s_reg.cfg[`CLC_CFG_MODE_HI:`CLC_CFG_MODE_LO] == 2'b00) begin
				s_next.center_p = 1'b1;
			end
			s_next.ctrl = pwdata[7:0];
		end
		if (wr && clc_hit(paddr, `CLC_IDX_TXID)) begin
			s_next.txid = pwdata[7:0];
		end
		if (wr && clc_hit(paddr, `CLC_IDX_CFG)) begin
			s_next.cfg = pwdata[7:0];
			if (pwdata[`CLC_CFG_REJOIN]) begin
				s_next.removed = 1'b0;
			end
		end
		if (rd && clc_hit(paddr, `CLC_IDX_STAT_A)) begin
			clr_a = 3'h7;
		end
		if (rd && clc_hit(paddr, `CLC_IDX_STAT_B)) begin
			clr_b = 7'h7f;
		end

		// read data and error are settled in the setup cycle
		if (psel && !penable) begin
			s_next.pslverr = 1'b0;
			if (clc_hit(paddr, `CLC_IDX_CTRL)) begin
				rbyte = s_reg.ctrl;
			end else if (clc_hit(paddr, `CLC_IDX_TXID)) begin
				rbyte = s_reg.txid;
			end else if (clc_hit(paddr, `CLC_IDX_CFG)) begin
				rbyte = s_reg.cfg;
			end else if (clc_hit(paddr, `CLC_IDX_STAT_A)) begin
				rbyte = {5'h00, s_reg.stat_a};
			end else if (clc_hit(paddr, `CLC_IDX_STAT_B)) begin
				rbyte = {1'b0, rx_oof, s_reg.stat_b[5:1], rx_remote_defect};
			end else if (clc_hit(paddr, `CLC_IDX_RXID)) begin
				rbyte = s_reg.rxid;
			end else if (clc_hit(paddr, `CLC_IDX_SYNC)) begin
				rbyte = {6'h00, s_reg.seen, s_reg.healthy};
			end else begin
				s_next.pslverr = 1'b1;
			end
			s_next.prdata = {24'h000000, rbyte};
		end

		// framing handshake: fill only from the next alignment pair
		unique case (s_reg.align)
			ALIGN_IDLE: begin
				if (!lost) begin
					s_next.align = ALIGN_WAIT;
				end
			end
			ALIGN_WAIT: begin
				if (lost) begin
					s_next.align = ALIGN_IDLE;
				end else if (rx_frame_start) begin
					s_next.align = ALIGN_RUN;
					s_next.seq_lock = 1'b0;
				end
			end
			ALIGN_RUN: begin
				if (lost) begin
					s_next.align = ALIGN_IDLE;
				end
			end
			default: begin
				s_next.align = ALIGN_IDLE;
			end
		endcase

		// playback of a complete accepted cell, one word a cycle
		// crossing into the port controller clock happens beyond this stream
		if (s_reg.out_act) begin
			s_next.ow = s_reg.mem[s_reg.ocnt];
			s_next.ov = 1'b1;
			s_next.osop = (s_reg.ocnt == '0);
			s_next.oeop = (s_reg.ocnt == LAST);
			if (s_reg.ocnt == LAST) begin
				s_next.out_act = 1'b0;
			end else begin
				s_next.ocnt = s_reg.ocnt + 1'b1;
			end
		end

		// a disabled or removed link is never read and restarts at a cell boundary
		if (s_reg.align != ALIGN_RUN || lost || s_reg.ctrl[`CLC_CTRL_RXOFF] || s_reg.removed) begin
			s_next.wcnt = '0;
		end else begin
			take = rx_word_valid;
		end

		if (take) begin
			s_next.mem[s_reg.wcnt] = rx_word;
			if (s_reg.wcnt == '0) begin
				serr = s_reg.seq_lock && (rx_word[31:24] != s_reg.exp_seq);
				s_next.exp_seq = rx_word[31:24] + 8'h01;
				s_next.seq_lock = 1'b1;
				s_next.par_acc = 8'h00;
				s_next.cell_serr = serr;
				s_next.seq_ind = serr;
				set_b[`CLC_SB_SEQ] = serr;
				if (serr) begin
					if (s_reg.serr_run != 8'hff) begin
						s_next.serr_run = s_reg.serr_run + 8'h01;
					end
					// nine bits so a saturated run still counts as excessive
					excess = ({1'b0, s_reg.serr_run} + 9'h001) >= {1'b0, EXCESS_SEQ};
				end else begin
					s_next.serr_run = 8'h00;
				end
			end else begin
				acc = s_reg.par_acc ^ clc_byte_xor(rx_word);
				s_next.par_acc = acc;
			end
			if (s_reg.wcnt == LAST) begin
				perr = acc != s_reg.mem[0][23:16];
				set_b[`CLC_SB_PAR] = perr;
				drop = (perr && !s_reg.ctrl[`CLC_CTRL_PINH]) ||
				       (s_reg.cell_serr && !s_reg.ctrl[`CLC_CTRL_SINH]);
				s_next.drop_p = drop;
				// completion overrides the end of the previous playback: order kept
				if (!drop) begin
					s_next.out_act = 1'b1;
					s_next.ocnt = '0;
				end
				s_next.wcnt = '0;
			end else begin
				s_next.wcnt = s_reg.wcnt + 1'b1;
			end
		end

		if (excess) begin
			set_b[`CLC_SB_EXSEQ] = 1'b1;
			if (s_reg.cfg[`CLC_CFG_AUTORM]) begin
				s_next.removed = 1'b1;
			end
		end

		// link-good only rises after two full stable frames in run
		if (s_reg.align == ALIGN_RUN && !lost && rx_frame_start && !s_reg.removed) begin
			if (s_reg.good_arm) begin
				s_next.healthy = 1'b1;
			end
			s_next.good_arm = 1'b1;
		end
		if (s_reg.align != ALIGN_RUN || lost || excess || s_next.removed) begin
			s_next.healthy = 1'b0;
			s_next.good_arm = 1'b0;
		end

		if (rx_frame_start && rx_frame_acquired) begin
			s_next.seen = 1'b1;
		end
		if (rx_oof) begin
			s_next.seen = 1'b0;
		end

		if (rx_f1_valid) begin
			s_next.rxid = rx_f1_byte;
		end

		set_a[`CLC_SA_ALIGN] = cell_align_err_evt;
		set_a[`CLC_SA_URUN] = tx_underrun_evt;
		set_a[`CLC_SA_ORUN] = tx_overrun_evt;
		set_b[`CLC_SB_SECT] = rx_section_parity_err;
		set_b[`CLC_SB_OVF] = rx_fifo_ovf_evt;
		// an event in the clearing read's cycle survives: set wins
		s_next.stat_a = (s_reg.stat_a & ~clr_a) | set_a;
		s_next.stat_b = (s_reg.stat_b & ~clr_b) | set_b;

		// idle only once the cell on the wire has finished
		if (s_reg.ctrl[`CLC_CTRL_TXOFF]) begin
			s_next.tx_idle = s_reg.tx_idle || !tx_cell_busy;
		end else begin
			s_next.tx_idle = 1'b0;
		end
		s_next.buf_en = !s_next.ctrl[`CLC_CTRL_LOOP];
		s_next.f1_out = s_next.ctrl[`CLC_CTRL_AUTO] ? s_next.txid : 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.ctrl <= `CLC_CTRL_RST;
			s_reg.txid <= `CLC_TXID_RST;
			s_reg.cfg <= `CLC_CFG_RST;
			s_reg.rxid <= `CLC_RXID_RST;
			s_reg.align <= ALIGN_IDLE;
			s_reg.buf_en <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata               = s_reg.prdata;
	assign pready               = s_reg.pready;
	assign pslverr              = s_reg.pslverr;
	assign cell_word            = s_reg.ow;
	assign cell_valid           = s_reg.ov;
	assign cell_sop             = s_reg.osop;
	assign cell_eop             = s_reg.oeop;
	assign seq_error_ind        = s_reg.seq_ind;
	assign cell_discard_pulse   = s_reg.drop_p;
	assign rx_lock_source_sel   = s_reg.ctrl[`CLC_CTRL_LOCK];
	assign internal_loopback_en = s_reg.ctrl[`CLC_CTRL_LOOP];
	assign hs_out_buf_en        = s_reg.buf_en;
	assign tx_send_idle         = s_reg.tx_idle;
	assign auto_overhead_gen    = s_reg.ctrl[`CLC_CTRL_AUTO];
	assign tx_f1_byte           = s_reg.f1_out;
	assign fifo_center_pulse    = s_reg.center_p;
	assign receive_link_healthy = s_reg.healthy;
	assign align_bytes_seen     = s_reg.seen;
endmodule : clc_rx_link
`default_nettype wire

// [testbench/clc_rx_link_chk.sv]
// port assertions for the cell receive link block
`timescale 1ns/100ps
`default_nettype none
`include "clc_rx_link_regs.svh"
module clc_rx_link_chk #(
	parameter int CELL_WORDS = 4
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [19:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               cell_valid,
	input wire logic               cell_sop,
	input wire logic               cell_eop,
	input wire logic               seq_error_ind,
	input wire logic               cell_discard_pulse,
	input wire logic               rx_lock_source_sel,
	input wire logic               internal_loopback_en,
	input wire logic               hs_out_buf_en,
	input wire logic               auto_overhead_gen,
	input wire clc_pkg::clc_byte_t tx_f1_byte,
	input wire logic               tx_send_idle,
	input wire logic               tx_cell_busy,
	input wire logic               fifo_center_pulse,
	input wire logic               receive_link_healthy,
	input wire logic               rx_frame_start
);
	import clc_pkg::*;
	logic       wr_ctrl;
	logic [7:0] ctrl_sh;
	// shadow of the control byte as written, so outputs can be tied to what software asked for
	assign wr_ctrl = psel && penable && pwrite && paddr == {`CLC_IDX_CTRL, 2'b00};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_sh <= 8'h00;
		else if (wr_ctrl)
			ctrl_sh <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	zero_wait_a: assert property ($past(presetn) |-> pready) else $error("pready low");
	rdata_pad_a: assert property (psel && penable |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	ctrl_out_a: assert property ({rx_lock_source_sel, internal_loopback_en, auto_overhead_gen}
		== {ctrl_sh[7], ctrl_sh[6], ctrl_sh[1]}) else $error("control output wrong");
	buf_off_a: assert property (hs_out_buf_en != internal_loopback_en)
		else $error("buffer enable wrong");
	f1_zero_a: assert property (!auto_overhead_gen && !$past(auto_overhead_gen) |->
		tx_f1_byte == 8'h00) else $error("f1 byte without auto overhead");
	center_cause_a: assert property (fifo_center_pulse |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
		else $error("centre pulse without write");
	whole_cell_a: assert property (cell_sop |-> cell_valid ##1
		(cell_valid && !cell_sop && !cell_eop)[*2] ##1 (cell_valid && cell_eop))
		else $error("cell not whole");
	drop_inhib_a: assert property ($stable(ctrl_sh) && ctrl_sh[3:2] == 2'b11 |->
		!cell_discard_pulse) else $error("drop while inhibited");
	idle_start_a: assert property ($rose(tx_send_idle) |-> !$past(tx_cell_busy))
		else $error("idle during cell");
	good_rise_a: assert property ($rose(receive_link_healthy) |->
		$past(rx_frame_start) || $past(rx_frame_start, 2)) else $error("healthy off boundary");
	seq_pulse_a: assert property (seq_error_ind |=> !seq_error_ind)
		else $error("sequence flag too long");
endmodule : clc_rx_link_chk
bind clc_rx_link clc_rx_link_chk #(.CELL_WORDS(CELL_WORDS)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.cell_valid, .cell_sop, .cell_eop, .seq_error_ind, .cell_discard_pulse,
	.rx_lock_source_sel, .internal_loopback_en, .hs_out_buf_en, .auto_overhead_gen,
	.tx_f1_byte, .tx_send_idle, .tx_cell_busy, .fifo_center_pulse,
	.receive_link_healthy, .rx_frame_start
);
`default_nettype wire

// [testbench/clc_fabric_sink.sv]
// fabric side model: takes cells, drop and sequence indications
`timescale 1ns/100ps
`default_nettype none
module clc_fabric_sink #(
	parameter int CELL_WORDS = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [31:0] cell_word,
	input wire logic        cell_valid,
	input wire logic        cell_sop,
	input wire logic        cell_eop,
	input wire logic        cell_discard_pulse,
	input wire logic        seq_error_ind,
	output int              n_cell,
	output int              n_drop,
	output int              n_seq,
	output int              n_bad,
	output logic [31:0]     last_hdr
);
	int len;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_cell   <= 0;
			n_drop   <= 0;
			n_seq    <= 0;
			n_bad    <= 0;
			len      <= 0;
			last_hdr <= 32'h0;
		end else begin
			n_drop <= n_drop + int'(cell_discard_pulse);
			n_seq  <= n_seq + int'(seq_error_ind);
			if (cell_valid) begin
				// no backpressure here, so a head out of place means a torn cell
				if (cell_sop != (len == 0) || cell_eop != (len == CELL_WORDS - 1))
					n_bad <= n_bad + 1;
				if (cell_sop)
					last_hdr <= cell_word;
				n_cell <= n_cell + int'(cell_eop);
				len    <= cell_eop ? 0 : len + 1;
			end
		end
	end
endmodule : clc_fabric_sink
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the cell receive link block
`timescale 1ns/100ps
`default_nettype none
`include "clc_rx_link_regs.svh"
module testbench;
	import clc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [19:0] paddr = 0;
	logic [31:0] pwdata = 0, rx_word = 0;
	logic rx_word_valid = 0, rx_frame_start = 0, rx_frame_acquired = 0, rx_oof = 0;
	logic rx_f1_valid = 0, rx_section_parity_err = 0, rx_remote_defect = 0, rx_fifo_ovf_evt = 0;
	logic cell_align_err_evt = 0, tx_underrun_evt = 0, tx_overrun_evt = 0, tx_cell_busy = 0;
	clc_byte_t rx_f1_byte = 0;
	wire logic [31:0] prdata, cell_word, last_hdr;
	wire clc_byte_t tx_f1_byte;
	wire logic pready, pslverr, cell_valid, cell_sop, cell_eop, seq_error_ind, cell_discard_pulse;
	wire logic rx_lock_source_sel, internal_loopback_en, hs_out_buf_en, tx_send_idle;
	wire logic auto_overhead_gen, fifo_center_pulse, receive_link_healthy, align_bytes_seen;
	int n_cell, n_drop, n_seq, n_bad, n_fail = 0, tests_run = 0;
	logic [7:0] rd;
	logic err;
	always #5 pclk = ~pclk;
	clc_rx_link #(.CELL_WORDS(4), .EXCESS_SEQ(8'h04)) u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rx_word, .rx_word_valid, .rx_frame_start, .rx_frame_acquired, .rx_oof, .rx_f1_valid,
		.rx_f1_byte, .rx_section_parity_err, .rx_remote_defect, .rx_fifo_ovf_evt,
		.cell_align_err_evt, .tx_underrun_evt, .tx_overrun_evt, .tx_cell_busy, .cell_word,
		.cell_valid, .cell_sop, .cell_eop, .seq_error_ind, .cell_discard_pulse,
		.rx_lock_source_sel, .internal_loopback_en, .hs_out_buf_en, .tx_send_idle,
		.auto_overhead_gen, .tx_f1_byte, .fifo_center_pulse, .receive_link_healthy,
		.align_bytes_seen
	);
	clc_fabric_sink #(.CELL_WORDS(4)) u_sink (.pclk, .presetn, .cell_word, .cell_valid,
		.cell_sop, .cell_eop, .cell_discard_pulse, .seq_error_ind, .n_cell, .n_drop, .n_seq,
		.n_bad, .last_hdr);
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [17:0] idx, input logic [7:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (i >= 16) begin
			n_fail++;
			stop_test();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdc(input string nm, input logic [17:0] idx, input logic [7:0] e);
		apb(0, idx, 8'h00);
		chk(nm, {24'h0, e}, {24'h0, rd});
	endtask : rdc
	task automatic send_cell(input logic [7:0] sq, input logic bad);
		logic [31:0] w[4];
		logic [7:0]  p;
		p = 8'h00;
		for (int k = 1; k < 4; k++) begin
			w[k] = {sq, 8'(k), 8'h5a, 8'hc3};
			p = p ^ w[k][31:24] ^ w[k][23:16] ^ w[k][15:8] ^ w[k][7:0];
		end
		w[0] = {sq, p ^ {7'h0, bad}, 16'h0};
		for (int k = 0; k < 4; k++) begin
			@(posedge pclk);
			rx_word <= w[k];
			rx_word_valid <= 1;
		end
		@(posedge pclk);
		rx_word_valid <= 0;
		rx_word <= ~w[3];
		repeat (7) @(posedge pclk);
	endtask : send_cell
	task automatic frame_pulse;
		@(posedge pclk) rx_frame_start <= 1;
		@(posedge pclk) rx_frame_start <= 0;
	endtask : frame_pulse
	task automatic align;
		@(posedge pclk) rx_frame_acquired <= 0;
		@(posedge pclk) rx_frame_acquired <= 1;
		frame_pulse();
	endtask : align
	task automatic t_regs;
		logic [17:0] ix[6] = '{`CLC_IDX_CTRL, `CLC_IDX_TXID, `CLC_IDX_STAT_A, `CLC_IDX_STAT_B,
			`CLC_IDX_RXID, `CLC_IDX_SYNC};
		foreach (ix[i]) rdc("reset value", ix[i], 8'h00);
		apb(0, 18'h30827, 8'h00);
		chk("unmapped error", 1, err);
		chk("buffer enable", 1, hs_out_buf_en);
	endtask : t_regs
	task automatic t_ctrl;
		int bs[3] = '{7, 6, 1};
		foreach (bs[i]) begin
			apb(1, `CLC_IDX_CTRL, 8'(1 << bs[i]));
			rdc("control", `CLC_IDX_CTRL, 8'(1 << bs[i]));
			chk("control pins", {bs[i] == 7, bs[i] == 6, bs[i] != 6, bs[i] == 1},
				{rx_lock_source_sel, internal_loopback_en, hs_out_buf_en, auto_overhead_gen});
		end
		apb(1, `CLC_IDX_TXID, 8'ha5);
		rdc("tx link id", `CLC_IDX_TXID, 8'ha5);
		repeat (2) @(posedge pclk);
		chk("f1 auto", 8'ha5, tx_f1_byte);
		apb(1, `CLC_IDX_CTRL, 8'h00);
		repeat (2) @(posedge pclk);
		chk("f1 off", 8'h00, tx_f1_byte);
	endtask : t_ctrl
	task automatic t_realign;
		logic seen;
		for (int m = 0; m < 2; m++) begin
			apb(1, `CLC_IDX_CFG, m ? 8'h10 : 8'h00);
			apb(1, `CLC_IDX_CTRL, 8'h00);
			apb(1, `CLC_IDX_CTRL, 8'h01);
			seen = 0;
			repeat (4) begin
				#1 seen |= fifo_center_pulse;
				@(posedge pclk);
			end
			chk("centre pulse", m ? 0 : 1, seen);
		end
		apb(1, `CLC_IDX_CFG, 8'h00);
		apb(1, `CLC_IDX_CTRL, 8'h00);
	endtask : t_realign
	task automatic t_idle;
		@(posedge pclk) tx_cell_busy <= 1;
		apb(1, `CLC_IDX_CTRL, 8'h20);
		repeat (3) @(posedge pclk);
		chk("idle held", 0, tx_send_idle);
		@(posedge pclk) tx_cell_busy <= 0;
		repeat (3) @(posedge pclk);
		chk("idle sent", 1, tx_send_idle);
		apb(1, `CLC_IDX_CTRL, 8'h00);
	endtask : t_idle
	task automatic t_events;
		@(posedge pclk) {cell_align_err_evt, tx_underrun_evt, tx_overrun_evt} <= 3'b111;
		@(posedge pclk) {cell_align_err_evt, tx_underrun_evt, tx_overrun_evt} <= 3'b000;
		rdc("status a", `CLC_IDX_STAT_A, 8'h07);
		apb(1, `CLC_IDX_STAT_A, 8'hff);
		rdc("status a cleared", `CLC_IDX_STAT_A, 8'h00);
	endtask : t_events
	task automatic t_cells;
		logic [7:0] ctl[5] = '{8'h00, 8'h0c, 8'h00, 8'h04, 8'h10};
		int ec[5] = '{1, 2, 1, 2, 0};
		int ed[5] = '{1, 0, 1, 0, 0};
		int c0, d0, s0;
		// words before the first alignment pair must not reach the fabric
		@(posedge pclk) rx_frame_acquired <= 1;
		c0 = n_cell;
		send_cell(8'h20, 0);
		chk("cells before align", 0, n_cell - c0);
		for (int i = 0; i < 5; i++) begin
			apb(1, `CLC_IDX_CTRL, ctl[i]);
			align();
			c0 = n_cell;
			d0 = n_drop;
			s0 = n_seq;
			send_cell(8'h20, 0);
			send_cell(i inside {2, 3} ? 8'h27 : 8'h21, i < 2);
			chk("cells out", ec[i], n_cell - c0);
			chk("cells dropped", ed[i], n_drop - d0);
			chk("sequence flags", i inside {2, 3}, n_seq - s0);
			if (ec[i] == 2)
				chk("cell order", i == 3 ? 8'h27 : 8'h21, last_hdr[31:24]);
		end
		@(posedge pclk) {rx_section_parity_err, rx_fifo_ovf_evt} <= 2'b11;
		@(posedge pclk) {rx_section_parity_err, rx_fifo_ovf_evt} <= 2'b00;
		rdc("status b", `CLC_IDX_STAT_B, 8'h1e);
		@(posedge pclk) {rx_oof, rx_remote_defect} <= 2'b11;
		rdc("status b oof", `CLC_IDX_STAT_B, 8'h41);
		@(posedge pclk) {rx_oof, rx_remote_defect} <= 2'b00;
	endtask : t_cells
	task automatic t_health;
		apb(1, `CLC_IDX_CTRL, 8'h00);
		align();
		frame_pulse();
		frame_pulse();
		@(posedge pclk) {rx_f1_valid, rx_f1_byte} <= {1'b1, 8'h3c};
		@(posedge pclk) rx_f1_valid <= 0;
		rdc("sync", `CLC_IDX_SYNC, 8'h03);
		chk("seen pin", 1, align_bytes_seen);
		chk("healthy pin", 1, receive_link_healthy);
		rdc("rx link id", `CLC_IDX_RXID, 8'h3c);
	endtask : t_health
	task automatic t_excess;
		int c0;
		apb(1, `CLC_IDX_CFG, 8'h80);
		send_cell(8'h20, 0);
		for (int k = 0; k < 4; k++) send_cell(k[0] ? 8'h40 : 8'h80, 0);
		c0 = n_cell;
		// the in-sequence header would pass if the link were still bundled
		send_cell(8'h41, 0);
		chk("removed link", 0, n_cell - c0);
		apb(0, `CLC_IDX_STAT_B, 8'h00);
		chk("excess flag", 8'h20, rd & 8'h20);
		apb(0, `CLC_IDX_SYNC, 8'h00);
		chk("healthy fell", 0, rd[0]);
		apb(1, `CLC_IDX_CFG, 8'h40);
		apb(1, `CLC_IDX_CFG, 8'h00);
		c0 = n_cell;
		send_cell(8'h41, 0);
		chk("rejoined link", 1, n_cell - c0);
	endtask : t_excess
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_ctrl();
		t_realign();
		t_idle();
		t_events();
		t_cells();
		t_health();
		t_excess();
		chk("cell framing", 0, n_bad);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
